// ===== common/carb_pkg.sv
`default_nettype none
package carb_pkg;
  // timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned SEC_MS           = 1000;
  localparam int unsigned SEC_CYCLES       = CLK_HZ / 1000 * SEC_MS;
  localparam int unsigned MAVG_STEP_MS     = 100;
  localparam int unsigned MAVG_STEP_CYCLES = CLK_HZ / 1000 * MAVG_STEP_MS;
  // holding register addresses
  localparam logic [15:0] A_HYST   = 16'h9c4c;
  localparam logic [15:0] A_DELAY  = 16'h9c4d;
  localparam logic [15:0] A_THR    = 16'h9c4e;
  localparam logic [15:0] A_THR2   = 16'h9c4f;
  localparam logic [15:0] A_MAVG   = 16'h9c50;
  localparam logic [15:0] A_RIPPLE = 16'h9c51;
  localparam logic [15:0] A_TEMP   = 16'h9c6c;
  localparam logic [15:0] A_RMS_LO = 16'h9c6d;
  localparam logic [15:0] A_RMS_HI = 16'h9c6e;
  localparam logic [15:0] A_SWITCH = 16'h9c6f;
  localparam logic [15:0] A_CMD    = 16'h9c70;
  localparam logic [15:0] A_STATUS = 16'h9c78;
  localparam logic [15:0] A_CENTI  = 16'h9c7a;
  localparam logic [15:0] A_SWP_LO = 16'h9c7b;
  localparam logic [15:0] A_SWP_HI = 16'h9c7c;
  localparam logic [15:0] A_AH_LO  = 16'h9c7d;
  localparam logic [15:0] A_AH_HI  = 16'h9c7e;
  localparam logic [15:0] A_MAX    = 16'h9c7f;
  localparam logic [15:0] A_MIN    = 16'h9c80;
  // accepted ranges
  localparam logic [15:0] HYST_MAX   = 16'h03e8;
  localparam logic [15:0] THR_MAX    = 16'h1388;
  localparam logic [15:0] THR2_MAX   = 16'h01f4;
  localparam logic [15:0] MAVG_MIN   = 16'h0001;
  localparam logic [15:0] MAVG_MAX   = 16'h0084;
  localparam logic [15:0] RIPPLE_MIN = 16'h03e8;
  localparam logic [15:0] RIPPLE_MAX = 16'h4e20;
  // reset values
  localparam logic [15:0] RST_HYST   = 16'h0000;
  localparam logic [15:0] RST_DELAY  = 16'h0000;
  localparam logic [15:0] RST_THR    = 16'h0000;
  localparam logic [15:0] RST_THR2   = 16'h0000;
  localparam logic [15:0] RST_MAVG   = 16'h0001;
  localparam logic [15:0] RST_RIPPLE = 16'h03e8;
  localparam logic [15:0] RST_CMD    = 16'h0000;
  localparam logic [15:0] PEAK_MAX_RST = 16'h8000;
  localparam logic [15:0] PEAK_MIN_RST = 16'h7fff;
  // command codes, request limits, exception codes
  localparam logic [15:0] CMD_SAVE   = 16'hc1c0;
  localparam logic [15:0] CMD_REBOOT = 16'hc1a0;
  localparam logic [15:0] MAX_WORDS  = 16'h0002;
  localparam logic [7:0]  EXC_NONE   = 8'h00;
  localparam logic [7:0]  EXC_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_VALUE  = 8'h03;
  // status bit positions
  localparam int unsigned ST_FLASH_SET = 0;
  localparam int unsigned ST_FLASH_CAL = 1;
  localparam int unsigned ST_OVER      = 2;
  localparam int unsigned ST_UNDER     = 3;
  localparam int unsigned ST_AH        = 4;
  localparam int unsigned ST_FILTER    = 5;
  localparam int unsigned ST_ALARM     = 6;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] count;
    logic [31:0] wdata;
  } carb_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [31:0] rdata;
  } carb_rsp_t;

  typedef struct packed {
    logic switch_closed;
    logic flash_set_err;
    logic flash_cal_err;
    logic over_range;
    logic under_range;
    logic filter_active;
    logic alarm_active;
  } carb_levels_t;

  typedef struct packed {
    logic               valid;
    logic [31:0]        rms_float;
    logic signed [15:0] centi;
    logic [15:0]        temp;
    logic [31:0]        ah_value;
    carb_levels_t       lv;
  } carb_meas_t;

  typedef struct packed {
    logic [15:0] hyst;
    logic [15:0] delay;
    logic [15:0] thr;
    logic [15:0] thr2;
    logic [15:0] mavg;
    logic [15:0] ripple;
  } carb_cfg_t;

  typedef struct packed {
    carb_cfg_t          cfg;
    logic [15:0]        cmd;
    logic [31:0]        rms_float;
    logic signed [15:0] centi;
    logic [15:0]        temp;
    logic [31:0]        ah;
    logic               ah_flag;
    carb_levels_t       lv;
    carb_rsp_t          rsp;
    logic               save;
    logic               reboot;
    logic               ah_clear;
    logic               clr_max;
    logic               clr_min;
    logic [31:0]        mavg_win;
    logic [31:0]        sec_cnt;
  } carb_state_t;

  typedef struct packed {
    logic signed [15:0] max;
    logic signed [15:0] min;
  } carb_peak_t;
endpackage
`default_nettype wire

// ===== hdl/carb_bank.sv
// Functional notes
// - hysteresis is unsigned, 10 mA per count, accepted 0 to 1000.
// - alarm threshold unsigned, 10 mA per count, accepted 0 to 5000.
// - second trigger threshold unsigned 16 bits, accepted 0 to 500.
// - moving-average length register sets window, 100 ms per count.
// - ripple filter setting unsigned 16 bits, accepted 1000 to 20000.
// - rms current float over two registers, low word at lower address.
// - rms current also as signed 16-bit hundredths of an ampere.
// - word-swapped copy of the rms float at its own register pair.
// - maximum rms current kept in hundredths, restarted by a register write.
// - minimum rms current kept in hundredths, restarted by a register write.
// - switch state register reads 0 open, 1 closed.
// - writing 0xc1c0 to the command register saves settings to flash.
// - writing 0xc1a0 to the command register reboots the device.
// - status bit 0 flash settings error, bit 1 flash calibration error.
// - status bit 2 over range, bit 3 under range.
// - status bit 4 flags ampere-hour update, once every second.
// - status bit 5 shows filter active.
// - status bit 6 shows alarm triggered.
// - one write request covers at most two contiguous registers.
`timescale 1ns/100ps
`default_nettype none
module carb_bank #(
  parameter int unsigned SEC_CYCLES = carb_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          srst,
  // decoded holding-register requests
  input  wire carb_pkg::carb_req_t  req,
  output carb_pkg::carb_rsp_t       rsp,
  // measurement front end
  input  wire carb_pkg::carb_meas_t meas,
  // settings and actions
  output carb_pkg::carb_cfg_t       cfg,
  output logic [31:0]               mavg_window_cycles,
  output logic                      save_pulse,
  output logic                      reboot_pulse,
  output logic                      ah_clear_pulse
);
  carb_pkg::carb_state_t s_q;
  carb_pkg::carb_state_t s_d;
  logic signed [15:0]    peak_max;
  logic signed [15:0]    peak_min;
  logic                  sec_tick;
  logic [15:0]           addr1;
  logic [7:0]            exc;

  function automatic logic is_mapped(input logic [15:0] a);
    unique case (a)
      carb_pkg::A_HYST, carb_pkg::A_DELAY, carb_pkg::A_THR, carb_pkg::A_THR2,
      carb_pkg::A_MAVG, carb_pkg::A_RIPPLE, carb_pkg::A_TEMP, carb_pkg::A_RMS_LO,
      carb_pkg::A_RMS_HI, carb_pkg::A_SWITCH, carb_pkg::A_CMD, carb_pkg::A_STATUS,
      carb_pkg::A_CENTI, carb_pkg::A_SWP_LO, carb_pkg::A_SWP_HI, carb_pkg::A_AH_LO,
      carb_pkg::A_AH_HI, carb_pkg::A_MAX, carb_pkg::A_MIN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v);
    unique case (a)
      carb_pkg::A_HYST:   value_ok = (v <= carb_pkg::HYST_MAX);
      carb_pkg::A_THR:    value_ok = (v <= carb_pkg::THR_MAX);
      carb_pkg::A_THR2:   value_ok = (v <= carb_pkg::THR2_MAX);
      carb_pkg::A_MAVG:   value_ok = (v >= carb_pkg::MAVG_MIN) && (v <= carb_pkg::MAVG_MAX);
      carb_pkg::A_RIPPLE: begin
        value_ok = (v >= carb_pkg::RIPPLE_MIN) && (v <= carb_pkg::RIPPLE_MAX);
      end
      default:            value_ok = 1'b1;
    endcase
  endfunction

  // whole request is checked before anything is stored, so a bad word leaves no half write
  function automatic logic [7:0] check_req(input carb_pkg::carb_req_t r,
                                           input logic [15:0] a1);
    logic two;
    two = (r.count == carb_pkg::MAX_WORDS);
    if ((r.count == 16'h0000) || (r.count > carb_pkg::MAX_WORDS)) begin
      check_req = carb_pkg::EXC_VALUE;
    end else if (!is_mapped(r.addr) || (two && !is_mapped(a1))) begin
      check_req = carb_pkg::EXC_ADDR;
    end else if (r.write && (!value_ok(r.addr, r.wdata[15:0]) ||
                             (two && !value_ok(a1, r.wdata[31:16])))) begin
      check_req = carb_pkg::EXC_VALUE;
    end else begin
      check_req = carb_pkg::EXC_NONE;
    end
  endfunction

  function automatic logic [15:0] rd_word(input carb_pkg::carb_state_t s,
                                          input logic [15:0] a,
                                          input logic signed [15:0] pmax,
                                          input logic signed [15:0] pmin);
    unique case (a)
      carb_pkg::A_HYST:   rd_word = s.cfg.hyst;
      carb_pkg::A_DELAY:  rd_word = s.cfg.delay;
      carb_pkg::A_THR:    rd_word = s.cfg.thr;
      carb_pkg::A_THR2:   rd_word = s.cfg.thr2;
      carb_pkg::A_MAVG:   rd_word = s.cfg.mavg;
      carb_pkg::A_RIPPLE: rd_word = s.cfg.ripple;
      carb_pkg::A_TEMP:   rd_word = s.temp;
      carb_pkg::A_RMS_LO: rd_word = s.rms_float[15:0];
      carb_pkg::A_RMS_HI: rd_word = s.rms_float[31:16];
      carb_pkg::A_SWITCH: rd_word = {15'h0000, s.lv.switch_closed};
      carb_pkg::A_CMD:    rd_word = s.cmd;
      carb_pkg::A_STATUS: begin
        rd_word = {9'h000, s.lv.alarm_active, s.lv.filter_active,
                   s.ah_flag, s.lv.under_range, s.lv.over_range,
                   s.lv.flash_cal_err, s.lv.flash_set_err};
      end
      carb_pkg::A_CENTI:  rd_word = s.centi;
      carb_pkg::A_SWP_LO: rd_word = s.rms_float[31:16];
      carb_pkg::A_SWP_HI: rd_word = s.rms_float[15:0];
      carb_pkg::A_AH_LO:  rd_word = s.ah[15:0];
      carb_pkg::A_AH_HI:  rd_word = s.ah[31:16];
      carb_pkg::A_MAX:    rd_word = pmax;
      carb_pkg::A_MIN:    rd_word = pmin;
      default:            rd_word = 16'h0000;
    endcase
  endfunction

  // rms, temperature, centi and switch registers take writes without effect, the front end owns them
  function automatic carb_pkg::carb_state_t apply_wr(input carb_pkg::carb_state_t s,
                                                     input logic [15:0] a,
                                                     input logic [15:0] v);
    carb_pkg::carb_state_t n;
    n = s;
    unique case (a)
      carb_pkg::A_HYST:   n.cfg.hyst = v;
      carb_pkg::A_DELAY:  n.cfg.delay = v;
      carb_pkg::A_THR:    n.cfg.thr = v;
      carb_pkg::A_THR2:   n.cfg.thr2 = v;
      carb_pkg::A_MAVG:   n.cfg.mavg = v;
      carb_pkg::A_RIPPLE: n.cfg.ripple = v;
      carb_pkg::A_CMD: begin
        n.cmd = v; // any other value is only kept, it starts nothing
        if (v == carb_pkg::CMD_SAVE) begin
          n.save = 1'b1;
        end else if (v == carb_pkg::CMD_REBOOT) begin
          n.reboot = 1'b1;
        end
      end
      carb_pkg::A_STATUS: begin
        if (v[carb_pkg::ST_AH]) begin
          n.ah_flag = 1'b0;
        end
      end
      carb_pkg::A_AH_LO, carb_pkg::A_AH_HI: begin
        n.ah = 32'h0000_0000;
        n.ah_clear = 1'b1;
      end
      carb_pkg::A_MAX:    n.clr_max = 1'b1;
      carb_pkg::A_MIN:    n.clr_min = 1'b1;
      default: ;
    endcase
    return n;
  endfunction

  assign addr1 = 16'(req.addr + 16'h0001);
  assign exc = check_req(req, addr1);
  assign sec_tick = (s_q.sec_cnt == 32'(SEC_CYCLES - 1));

  always_comb begin
    s_d = s_q;
    s_d.rsp = '0;
    s_d.save = 1'b0;
    s_d.reboot = 1'b0;
    s_d.ah_clear = 1'b0;
    s_d.clr_max = 1'b0;
    s_d.clr_min = 1'b0;
    s_d.lv = meas.lv;
    if (meas.valid) begin
      s_d.rms_float = meas.rms_float;
      s_d.centi = meas.centi;
      s_d.temp = meas.temp;
    end
    s_d.mavg_win = 32'(s_q.cfg.mavg) * 32'(carb_pkg::MAVG_STEP_CYCLES);
    s_d.sec_cnt = sec_tick ? 32'h0000_0000 : 32'(s_q.sec_cnt + 32'h0000_0001);
    if (sec_tick) begin
      s_d.ah = meas.ah_value;
    end
    if (req.valid) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.exc = exc;
      if (exc == carb_pkg::EXC_NONE) begin
        if (req.write) begin
          s_d = apply_wr(s_d, req.addr, req.wdata[15:0]);
          if (req.count == carb_pkg::MAX_WORDS) begin
            s_d = apply_wr(s_d, addr1, req.wdata[31:16]);
          end
        end else begin
          s_d.rsp.rdata[15:0] = rd_word(s_q, req.addr, peak_max, peak_min);
          if (req.count == carb_pkg::MAX_WORDS) begin
            s_d.rsp.rdata[31:16] = rd_word(s_q, addr1, peak_max, peak_min);
          end
        end
      end
    end
    // the second tick wins over a clear written in the same cycle
    if (sec_tick) begin
      s_d.ah_flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
      s_q.cfg <= {carb_pkg::RST_HYST, carb_pkg::RST_DELAY, carb_pkg::RST_THR,
                  carb_pkg::RST_THR2, carb_pkg::RST_MAVG, carb_pkg::RST_RIPPLE};
      s_q.cmd <= carb_pkg::RST_CMD;
      s_q.mavg_win <= 32'(carb_pkg::MAVG_STEP_CYCLES);
    end else begin
      s_q <= s_d;
    end
  end

  carb_peak u_peak (
    .clock        (clock),
    .srst         (srst),
    .sample_valid (meas.valid),
    .sample       (meas.centi),
    .clear_max    (s_q.clr_max),
    .clear_min    (s_q.clr_min),
    .max_q        (peak_max),
    .min_q        (peak_min)
  );

  assign rsp = s_q.rsp;
  assign cfg = s_q.cfg;
  assign mavg_window_cycles = s_q.mavg_win;
  assign save_pulse = s_q.save;
  assign reboot_pulse = s_q.reboot;
  assign ah_clear_pulse = s_q.ah_clear;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_save;
    req.valid && req.write && (req.count == 16'h0001) && (req.addr == carb_pkg::A_CMD) &&
      (req.wdata[15:0] == carb_pkg::CMD_SAVE) |=> save_pulse && !reboot_pulse;
  endproperty
  a_save: assert property (p_save) else $error("save code did not save");

  property p_reboot;
    req.valid && req.write && (req.count == 16'h0001) && (req.addr == carb_pkg::A_CMD) &&
      (req.wdata[15:0] == carb_pkg::CMD_REBOOT) |=> reboot_pulse && !save_pulse;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot code did not reboot");

  property p_cmd_cause;
    (save_pulse || reboot_pulse) |-> $past(req.valid) && $past(req.write) &&
      (rsp.exc == carb_pkg::EXC_NONE) &&
      ((s_q.cmd == carb_pkg::CMD_SAVE) || (s_q.cmd == carb_pkg::CMD_REBOOT));
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("action without its code");

  property p_hyst_range;
    cfg.hyst <= carb_pkg::HYST_MAX;
  endproperty
  a_hyst_range: assert property (p_hyst_range) else $error("hysteresis out of range");

  property p_thr_range;
    (cfg.thr <= carb_pkg::THR_MAX) && (cfg.thr2 <= carb_pkg::THR2_MAX);
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");

  property p_ripple_range;
    (cfg.ripple >= carb_pkg::RIPPLE_MIN) && (cfg.ripple <= carb_pkg::RIPPLE_MAX);
  endproperty
  a_ripple_range: assert property (p_ripple_range) else $error("ripple out of range");

  property p_mavg_win;
    $changed(cfg.mavg) |=>
      (mavg_window_cycles == 32'($past(cfg.mavg)) * 32'(carb_pkg::MAVG_STEP_CYCLES));
  endproperty
  a_mavg_win: assert property (p_mavg_win) else $error("averaging window wrong");

  property p_ah_set;
    sec_tick |=> s_q.ah_flag && (s_q.ah == $past(meas.ah_value) || ah_clear_pulse);
  endproperty
  a_ah_set: assert property (p_ah_set) else $error("second tick lost");

  property p_count_limit;
    req.valid && (req.count > carb_pkg::MAX_WORDS) |=>
      rsp.valid && (rsp.exc == carb_pkg::EXC_VALUE) && !save_pulse && !reboot_pulse;
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("long request taken");

  property p_status_rd;
    req.valid && !req.write && (req.count == 16'h0001) && (req.addr == carb_pkg::A_STATUS)
      |=> rsp.rdata[6:0] == {$past(s_q.lv.alarm_active), $past(s_q.lv.filter_active),
                             $past(s_q.ah_flag), $past(s_q.lv.under_range),
                             $past(s_q.lv.over_range), $past(s_q.lv.flash_cal_err),
                             $past(s_q.lv.flash_set_err)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_refused_keeps;
    req.valid && (exc != carb_pkg::EXC_NONE) |=>
      (cfg == $past(cfg)) && !save_pulse && !reboot_pulse && !ah_clear_pulse;
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("refused request stored");

  property p_other_cmd;
    req.valid && req.write && (req.count == 16'h0001) && (req.addr == carb_pkg::A_CMD) &&
      (req.wdata[15:0] != carb_pkg::CMD_SAVE) && (req.wdata[15:0] != carb_pkg::CMD_REBOOT)
      |=> !save_pulse && !reboot_pulse;
  endproperty
  a_other_cmd: assert property (p_other_cmd) else $error("unknown code acted");

  property p_switch_rd;
    req.valid && !req.write && (req.count == 16'h0001) && (req.addr == carb_pkg::A_SWITCH)
      |=> rsp.rdata == {31'h0000_0000, $past(s_q.lv.switch_closed)};
  endproperty
  a_switch_rd: assert property (p_switch_rd) else $error("switch read wrong");

  property p_float_words;
    req.valid && !req.write && (req.count == carb_pkg::MAX_WORDS) &&
      (req.addr == carb_pkg::A_RMS_LO) |=> rsp.rdata == $past(s_q.rms_float);
  endproperty
  a_float_words: assert property (p_float_words) else $error("float word order wrong");

  property p_swap_words;
    req.valid && !req.write && (req.count == carb_pkg::MAX_WORDS) &&
      (req.addr == carb_pkg::A_SWP_LO) |=>
      rsp.rdata == {$past(s_q.rms_float[15:0]), $past(s_q.rms_float[31:16])};
  endproperty
  a_swap_words: assert property (p_swap_words) else $error("swapped float wrong");

  property p_cv_save;
    save_pulse;
  endproperty
  c_save: cover property (p_cv_save);

  property p_cv_reboot;
    reboot_pulse;
  endproperty
  c_reboot: cover property (p_cv_reboot);

  property p_cv_pair;
    req.valid && req.write && (req.count == carb_pkg::MAX_WORDS) && (exc == carb_pkg::EXC_NONE);
  endproperty
  c_pair: cover property (p_cv_pair);

  property p_cv_ah;
    sec_tick ##1 s_q.ah_flag;
  endproperty
  c_ah: cover property (p_cv_ah);
endmodule
`default_nettype wire

// ===== hdl/carb_peak.sv
`timescale 1ns/100ps
`default_nettype none
module carb_peak (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               srst,
  // samples
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample,
  // restarts from the register side
  input  wire logic               clear_max,
  input  wire logic               clear_min,
  // extremes
  output logic signed [15:0]      max_q,
  output logic signed [15:0]      min_q
);
  carb_pkg::carb_peak_t p_q;
  carb_pkg::carb_peak_t p_d;

  always_comb begin
    p_d = p_q;
    if (clear_max) begin
      p_d.max = carb_pkg::PEAK_MAX_RST;
    end
    if (clear_min) begin
      p_d.min = carb_pkg::PEAK_MIN_RST;
    end
    // a sample in the clear cycle still counts
    if (sample_valid && (sample > p_d.max)) begin
      p_d.max = sample;
    end
    if (sample_valid && (sample < p_d.min)) begin
      p_d.min = sample;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      p_q <= {carb_pkg::PEAK_MAX_RST, carb_pkg::PEAK_MIN_RST};
    end else begin
      p_q <= p_d;
    end
  end

  assign max_q = p_q.max;
  assign min_q = p_q.min;

  property p_max_track;
    @(posedge clock) disable iff (srst)
      sample_valid |=> (max_q >= $past(sample));
  endproperty
  a_max_track: assert property (p_max_track) else $error("max below sample");

  property p_min_track;
    @(posedge clock) disable iff (srst)
      sample_valid |=> (min_q <= $past(sample));
  endproperty
  a_min_track: assert property (p_min_track) else $error("min above sample");
endmodule
`default_nettype wire

// ===== test/carb_master.sv
`timescale 1ns/100ps
`default_nettype none
module carb_master (
  // clock
  input  wire logic                clock,
  // register requests
  output carb_pkg::carb_req_t      req,
  input  wire carb_pkg::carb_rsp_t rsp
);
  initial req = '0;

  // one-cycle request, then a bounded wait for the answer
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] n,
                      input logic [31:0] wd, output carb_pkg::carb_rsp_t r,
                      output logic ok);
    int i;
    @(posedge clock);
    #1;
    req = {1'b1, w, a, n, wd};
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      #1;
      if (i == 0) begin
        // released address, count and data lines never keep the old value; the write line keeps it
        req = {1'b0, w, ~a, ~n, ~wd};
      end
      ok = (rsp.valid === 1'b1);
    end
    r = rsp;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_carb_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_carb_bank;
  localparam int unsigned SEC = 200;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] TWO = 16'h0002;
  logic                 clock;
  logic                 srst;
  carb_pkg::carb_req_t  req;
  carb_pkg::carb_rsp_t  rsp;
  carb_pkg::carb_meas_t meas;
  carb_pkg::carb_cfg_t  cfg;
  logic [31:0]          mavg_window_cycles;
  logic                 save_pulse;
  logic                 reboot_pulse;
  logic                 ah_clear_pulse;
  carb_pkg::carb_rsp_t  r;
  logic                 ok;
  int                   fail_count;
  int                   n_tests;
  int                   i;
  logic [15:0] ta [7] = '{16'h9c50, 16'h9c51, 16'h9c4c, 16'h9c4e, 16'h9c4f, 16'h9c50, 16'h9c51};
  logic [15:0] tg [7] = '{16'h0001, 16'h03e8, 16'h03e8, 16'h1388, 16'h01f4, 16'h0084, 16'h4e20};
  logic [15:0] tx [7] = '{16'h0000, 16'h03e7, 16'h03e9, 16'h1389, 16'h01f5, 16'h0085, 16'h4e21};
  logic [15:0] cc [4] = '{16'hc1c0, 16'hc1a0, 16'h1234, 16'hc1c1};
  logic [15:0] st [6] = '{16'h0040, 16'h0020, 16'h0008, 16'h0004, 16'h0002, 16'h0001};

  carb_bank #(.SEC_CYCLES(SEC)) carb_bank_i (
    .clock(clock), .srst(srst), .req(req), .rsp(rsp), .meas(meas), .cfg(cfg),
    .mavg_window_cycles(mavg_window_cycles), .save_pulse(save_pulse),
    .reboot_pulse(reboot_pulse), .ah_clear_pulse(ah_clear_pulse));
  carb_master carb_master_i (.clock(clock), .req(req), .rsp(rsp));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] n,
                     input logic [31:0] wd, input logic [7:0] ex);
    carb_master_i.xfer(w, a, n, wd, r, ok);
    if (!ok) begin
      chk("response", 32'h1, 32'h0);
      end_of_test();
    end
    chk("exception", {24'h0, ex}, {24'h0, r.exc});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] n, input logic [31:0] e);
    acc(1'b0, a, n, 32'h0, 8'h00);
    chk("read data", e, r.rdata);
  endtask

  task automatic sample(input logic [31:0] f, input logic [15:0] c);
    @(posedge clock);
    #1;
    meas.rms_float = f;
    meas.centi = c;
    meas.temp = ~c;
    meas.valid = 1'b1;
    @(posedge clock);
    #1;
    meas.valid = 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    fail_count = 0;
    n_tests = 0;
    srst = 1'b1;
    meas = '0;
    repeat (16) @(posedge clock);
    #1;
    srst = 1'b0;
    chk("hysteresis out", 32'h0, {16'h0, cfg.hyst});
    rd(16'h9c4c, TWO, 32'h0);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      acc(1'b1, ta[i], ONE, {16'h0, tg[i]}, 8'h00);
      acc(1'b1, ta[i], ONE, {16'h0, tx[i]}, 8'h03);
      rd(ta[i], ONE, {16'h0, tg[i]});
    end
    chk("window", 32'd132 * carb_pkg::MAVG_STEP_CYCLES, mavg_window_cycles);
    acc(1'b1, 16'h9c4d, TWO, 32'h1389_0007, 8'h03);
    rd(16'h9c4d, ONE, 32'h0);
    $display("test limits done");
    acc(1'b0, 16'h9c4c, 16'h0003, 32'h0, 8'h03);
    acc(1'b0, 16'h9c4c, 16'h0000, 32'h0, 8'h03);
    acc(1'b1, 16'h9c51, TWO, 32'h0, 8'h02);
    acc(1'b0, 16'h9c52, ONE, 32'h0, 8'h02);
    $display("test refusals done");
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 16'h9c70, ONE, {16'h0, cc[i]}, 8'h00);
      chk("save", {31'h0, i == 0}, {31'h0, save_pulse});
      chk("reboot", {31'h0, i == 1}, {31'h0, reboot_pulse});
    end
    $display("test commands done");
    sample(32'h41a8_0000, 16'h0064);
    sample(32'hc0a0_0000, 16'hffce);
    rd(16'h9c6d, TWO, 32'hc0a0_0000);
    rd(16'h9c7b, TWO, 32'h0000_c0a0);
    rd(16'h9c7a, ONE, 32'h0000_ffce);
    rd(16'h9c6c, ONE, 32'h0000_0031);
    rd(16'h9c7f, TWO, 32'hffce_0064);
    acc(1'b1, 16'h9c7f, ONE, 32'h0, 8'h00);
    repeat (2) @(posedge clock);
    rd(16'h9c7f, TWO, 32'hffce_8000);
    acc(1'b1, 16'h9c80, ONE, 32'h0, 8'h00);
    repeat (2) @(posedge clock);
    rd(16'h9c7f, TWO, 32'h7fff_8000);
    $display("test measurement done");
    for (i = 0; i < 6; i++) begin
      meas.lv = 7'h01 << i;
      acc(1'b0, 16'h9c78, ONE, 32'h0, 8'h00);
      chk("status", {16'h0, st[i]}, r.rdata & 32'h0000_ffef);
    end
    meas.lv = 7'h40;
    rd(16'h9c6f, ONE, 32'h1);
    meas.lv = 7'h00;
    rd(16'h9c6f, ONE, 32'h0);
    $display("test status done");
    meas.ah_value = 32'h1234_5678;
    // no second has passed yet, so the flag is still down; clear it so the poll waits for a new tick
    acc(1'b1, 16'h9c78, ONE, 32'h0010, 8'h00);
    i = 0;
    do begin
      acc(1'b0, 16'h9c78, ONE, 32'h0, 8'h00);
      i++;
    end while (r.rdata[4] !== 1'b1 && i < SEC);
    chk("second flag", 32'h1, {31'h0, r.rdata[4]});
    if (r.rdata[4] !== 1'b1) begin
      end_of_test();
    end
    rd(16'h9c7d, TWO, 32'h1234_5678);
    acc(1'b1, 16'h9c78, ONE, 32'h0010, 8'h00);
    rd(16'h9c78, ONE, 32'h0);
    acc(1'b1, 16'h9c7d, ONE, 32'h0, 8'h00);
    chk("amp hour clear", 32'h1, {31'h0, ah_clear_pulse});
    rd(16'h9c7d, TWO, 32'h0);
    $display("test amp hour done");
    end_of_test();
  end
endmodule
`default_nettype wire
